// ==== shared/canaf_pkg.sv ====
// Overview of operation
// - Compare only mask-enabled bits; all must match.
// - Remote-request bit takes part in comparison.
// - Extension bit compared only in mixed mode.
// - Identifier and mask laid out as four bytes.
// - FIFO mode offers two independent acceptance filters.
// - FIFO filters use FIFO compare registers.
// - Masks six and seven pair compares zero, one.
// - Each received message loads filter-support register.
// - Support read: bits 10..3 plus one-hot low bits.
// - Support unit handles standard identifiers only.
package canaf_pkg;
    localparam logic [7:0] ADDR_MAILBOX_ID = 8'h00;
    localparam logic [7:0] ADDR_MASK_ZERO = 8'h04;
    localparam logic [7:0] ADDR_MASK_SIX = 8'h08;
    localparam logic [7:0] ADDR_MASK_SEVEN = 8'h0c;
    localparam logic [7:0] ADDR_FIFO_CMP_ZERO = 8'h10;
    localparam logic [7:0] ADDR_FIFO_CMP_ONE = 8'h14;
    localparam logic [7:0] ADDR_CONTROL = 8'h18;
    localparam logic [7:0] ADDR_FILTER_SUPPORT = 8'h1c;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam int CTRL_ID_FORMAT_SELECT_LSB = 0;
    localparam int CTRL_FIFO_BIT = 2;
    localparam logic [1:0] ID_FORMAT_SELECT_MIXED = 2'h2;
    localparam int IDE_BIT = 31;
    localparam int RTR_BIT = 30;
    localparam int SID_HI_LSB = 24;
    localparam int SID_LO_LSB = 18;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic ide;
        logic rtr;
        logic [10:0] standard_id_bit;
        logic [17:0] extended_id_bit;
    } canaf_id_t;

    typedef struct packed {
        logic valid;
        canaf_id_t id;
    } canaf_rx_t;

    typedef struct packed {
        logic valid;
        logic accept;
        logic to_fifo;
    } canaf_verdict_t;
endpackage : canaf_pkg

// ==== core/canaf_filter.sv ====
`timescale 1ns/100ps
module canaf_filter (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire canaf_pkg::canaf_rx_t rx_in,
    output canaf_pkg::canaf_verdict_t verdict
);
    logic [31:0] mailbox_id;
    logic [31:0] id_mask_register_zero;
    logic [31:0] id_mask_register_six;
    logic [31:0] id_mask_register_seven;
    logic [31:0] fifo_id_compare_zero;
    logic [31:0] fifo_id_compare_one;
    logic [31:0] channel_control_register;
    logic [10:0] filter_support_register;
    logic [7:0] match_count;

    // Write path: address and data are captured independently, in any order.
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_go = aw_held && w_held && !s_axi_bvalid;
    wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    wire [7:0] wa = {aw_addr[7:2], 2'b00};
    wire wr_hit_mb = wr_go && wa == canaf_pkg::ADDR_MAILBOX_ID;
    wire wr_hit_m0 = wr_go && wa == canaf_pkg::ADDR_MASK_ZERO;
    wire wr_hit_m6 = wr_go && wa == canaf_pkg::ADDR_MASK_SIX;
    wire wr_hit_m7 = wr_go && wa == canaf_pkg::ADDR_MASK_SEVEN;
    wire wr_hit_f0 = wr_go && wa == canaf_pkg::ADDR_FIFO_CMP_ZERO;
    wire wr_hit_f1 = wr_go && wa == canaf_pkg::ADDR_FIFO_CMP_ONE;
    wire wr_hit_ct = wr_go && wa == canaf_pkg::ADDR_CONTROL;
    wire wr_known = wr_hit_mb || wr_hit_m0 || wr_hit_m6 || wr_hit_m7
        || wr_hit_f0 || wr_hit_f1 || wr_hit_ct;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= canaf_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !aw_take && !s_axi_bvalid;
            s_axi_wready <= !w_held && !w_take && !s_axi_bvalid;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? canaf_pkg::RESP_OKAY : canaf_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Reference and mask words share the four-byte layout of the identifier.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction : merge

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mailbox_id <= canaf_pkg::REG_RESET;
            id_mask_register_zero <= canaf_pkg::REG_RESET;
            id_mask_register_six <= canaf_pkg::REG_RESET;
            id_mask_register_seven <= canaf_pkg::REG_RESET;
            fifo_id_compare_zero <= canaf_pkg::REG_RESET;
            fifo_id_compare_one <= canaf_pkg::REG_RESET;
            channel_control_register <= canaf_pkg::REG_RESET;
        end else begin
            if (wr_hit_mb) mailbox_id <= merge(mailbox_id, w_data, wmask);
            if (wr_hit_m0) id_mask_register_zero <= merge(id_mask_register_zero, w_data, wmask);
            if (wr_hit_m6) id_mask_register_six <= merge(id_mask_register_six, w_data, wmask);
            if (wr_hit_m7) id_mask_register_seven <= merge(id_mask_register_seven, w_data, wmask);
            if (wr_hit_f0) fifo_id_compare_zero <= merge(fifo_id_compare_zero, w_data, wmask);
            if (wr_hit_f1) fifo_id_compare_one <= merge(fifo_id_compare_one, w_data, wmask);
            if (wr_hit_ct) begin
                channel_control_register <= merge(channel_control_register, w_data, wmask)
                    & 32'h0000_0007;
            end
        end
    end

    // Received identifier packed into the same byte layout as the registers.
    // Bit 29 has no identifier bit behind it and is always zero.
    wire [31:0] rx_word = {rx_in.id.ide, rx_in.id.rtr, 1'b0, rx_in.id.standard_id_bit,
        rx_in.id.extended_id_bit};
    wire [1:0] id_format_select = channel_control_register[canaf_pkg::CTRL_ID_FORMAT_SELECT_LSB +: 2];
    wire fifo_mode = channel_control_register[canaf_pkg::CTRL_FIFO_BIT];
    // Outside mixed mode the extension bit is forced out of every comparison,
    // so a stray one written there by software cannot block reception.
    wire ide_keep = id_format_select == canaf_pkg::ID_FORMAT_SELECT_MIXED;
    wire [31:0] fmt_mask = {ide_keep, 31'h7fff_ffff};

    // Each filter passes when no compared bit differs.
    wire [31:0] diff_mb = (rx_word ^ mailbox_id) & id_mask_register_zero & fmt_mask;
    wire [31:0] diff_f0 = (rx_word ^ fifo_id_compare_zero) & id_mask_register_six
        & fmt_mask;
    wire [31:0] diff_f1 = (rx_word ^ fifo_id_compare_one) & id_mask_register_seven
        & fmt_mask;
    wire hit_mb = diff_mb == 32'h0000_0000;
    wire hit_fifo = (diff_f0 == 32'h0000_0000) || (diff_f1 == 32'h0000_0000);
    wire next_accept = fifo_mode ? hit_fifo : hit_mb;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            verdict <= '0;
            filter_support_register <= 11'h000;
            match_count <= 8'h00;
        end else begin
            verdict.valid <= rx_in.valid;
            verdict.to_fifo <= rx_in.valid && fifo_mode;
            verdict.accept <= rx_in.valid && next_accept;
            if (rx_in.valid) begin
                // Only the standard part is kept; extended bits have no place here.
                filter_support_register <= rx_in.id.standard_id_bit;
                if (next_accept) match_count <= match_count + 8'h01;
            end
        end
    end

    // Support read value: upper byte and one-hot decoded lower three bits.
    wire [7:0] onehot = 8'h01 << filter_support_register[2:0];
    wire [31:0] support_word = {16'h0000, filter_support_register[10:3], onehot};
    wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
    logic [31:0] next_rdata;
    logic next_rok;
    always_comb begin
        next_rok = 1'b1;
        case (ra)
            canaf_pkg::ADDR_MAILBOX_ID: next_rdata = mailbox_id;
            canaf_pkg::ADDR_MASK_ZERO: next_rdata = id_mask_register_zero;
            canaf_pkg::ADDR_MASK_SIX: next_rdata = id_mask_register_six;
            canaf_pkg::ADDR_MASK_SEVEN: next_rdata = id_mask_register_seven;
            canaf_pkg::ADDR_FIFO_CMP_ZERO: next_rdata = fifo_id_compare_zero;
            canaf_pkg::ADDR_FIFO_CMP_ONE: next_rdata = fifo_id_compare_one;
            canaf_pkg::ADDR_CONTROL: next_rdata = channel_control_register;
            canaf_pkg::ADDR_FILTER_SUPPORT: next_rdata = support_word;
            canaf_pkg::ADDR_STATUS: next_rdata = {24'h000000, match_count};
            default: begin
                next_rdata = 32'h0000_0000;
                next_rok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= canaf_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= next_rok ? canaf_pkg::RESP_OKAY : canaf_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    property p_mailbox_accept;
        @(posedge clk) disable iff (!rstn)
        (rx_in.valid && !fifo_mode) |=> verdict.accept == $past(hit_mb);
    endproperty
    a_mailbox_accept: assert property (p_mailbox_accept) else $error("mailbox verdict");

    property p_rtr_compared;
        @(posedge clk) disable iff (!rstn)
        (rx_in.valid && !fifo_mode && id_mask_register_zero[canaf_pkg::RTR_BIT]
            && rx_in.id.rtr != mailbox_id[canaf_pkg::RTR_BIT]) |=> !verdict.accept;
    endproperty
    a_rtr_compared: assert property (p_rtr_compared) else $error("remote bit ignored");

    property p_ide_excluded;
        @(posedge clk) disable iff (!rstn)
        (rx_in.valid && !ide_keep && !fifo_mode && (((rx_word ^ mailbox_id)
            & id_mask_register_zero & 32'h7fff_ffff) == 32'h0000_0000)) |=> verdict.accept;
    endproperty
    a_ide_excluded: assert property (p_ide_excluded) else $error("extension bit compared");

    property p_ide_mixed;
        @(posedge clk) disable iff (!rstn)
        (rx_in.valid && ide_keep && !fifo_mode && id_mask_register_zero[canaf_pkg::IDE_BIT]
            && rx_in.id.ide != mailbox_id[canaf_pkg::IDE_BIT]) |=> !verdict.accept;
    endproperty
    a_ide_mixed: assert property (p_ide_mixed) else $error("mixed extension bit ignored");

    property p_layout;
        @(posedge clk) disable iff (!rstn)
        rx_in.valid |-> rx_word[canaf_pkg::SID_HI_LSB +: 5] == rx_in.id.standard_id_bit[10:6]
            && rx_word[canaf_pkg::SID_LO_LSB +: 6] == rx_in.id.standard_id_bit[5:0]
            && rx_word[canaf_pkg::IDE_BIT] == rx_in.id.ide
            && rx_word[canaf_pkg::RTR_BIT] == rx_in.id.rtr;
    endproperty
    a_layout: assert property (p_layout) else $error("identifier layout wrong");

    property p_fifo_either;
        @(posedge clk) disable iff (!rstn)
        (rx_in.valid && fifo_mode) |=> verdict.to_fifo
            && verdict.accept == ($past(diff_f0) == 32'h0 || $past(diff_f1) == 32'h0);
    endproperty
    a_fifo_either: assert property (p_fifo_either) else $error("fifo verdict");

    property p_support_load;
        @(posedge clk) disable iff (!rstn)
        rx_in.valid |=> filter_support_register == $past(rx_in.id.standard_id_bit);
    endproperty
    a_support_load: assert property (p_support_load) else $error("support stale");

    property p_support_hold;
        @(posedge clk) disable iff (!rstn)
        !rx_in.valid |=> $stable(filter_support_register);
    endproperty
    a_support_hold: assert property (p_support_hold) else $error("support changed idle");

    property p_onehot;
        @(posedge clk) disable iff (!rstn)
        $onehot(support_word[7:0]) && support_word[15:8] == filter_support_register[10:3]
            && support_word[filter_support_register[2:0]];
    endproperty
    a_onehot: assert property (p_onehot) else $error("support decode wrong");

    // Every received message yields exactly one verdict pulse, one cycle later.
    property p_verdict_pulse;
        @(posedge clk) disable iff (!rstn)
        1'b1 |=> verdict.valid == $past(rx_in.valid);
    endproperty
    a_verdict_pulse: assert property (p_verdict_pulse) else $error("verdict pulse wrong");

    property p_idle_quiet;
        @(posedge clk) disable iff (!rstn)
        !rx_in.valid |=> !verdict.accept && !verdict.to_fifo;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("verdict without message");

    property p_mailbox_no_fifo;
        @(posedge clk) disable iff (!rstn)
        (rx_in.valid && !fifo_mode) |=> !verdict.to_fifo;
    endproperty
    a_mailbox_no_fifo: assert property (p_mailbox_no_fifo) else $error("fifo flag wrong");

    property p_fifo_zero;
        @(posedge clk) disable iff (!rstn)
        (rx_in.valid && fifo_mode && (((rx_word ^ fifo_id_compare_zero)
            & id_mask_register_six & fmt_mask) == 32'h0000_0000)) |=> verdict.accept;
    endproperty
    a_fifo_zero: assert property (p_fifo_zero) else $error("filter zero ignored");

    property p_fifo_one;
        @(posedge clk) disable iff (!rstn)
        (rx_in.valid && fifo_mode && (((rx_word ^ fifo_id_compare_one)
            & id_mask_register_seven & fmt_mask) == 32'h0000_0000)) |=> verdict.accept;
    endproperty
    a_fifo_one: assert property (p_fifo_one) else $error("filter one ignored");

    property p_fifo_skips_mailbox;
        @(posedge clk) disable iff (!rstn)
        (rx_in.valid && fifo_mode && hit_mb && !hit_fifo) |=> !verdict.accept;
    endproperty
    a_fifo_skips_mailbox: assert property (p_fifo_skips_mailbox) else $error("mailbox used");

    // The counter wraps, so software should compare differences, not totals.
    property p_count;
        @(posedge clk) disable iff (!rstn)
        (rx_in.valid && next_accept) |=> match_count == $past(match_count) + 8'h01;
    endproperty
    a_count: assert property (p_count) else $error("accept count wrong");

    // The write and read paths each answer one request at a time; a second request waits for the
    // response handshake instead of being queued.
    property p_write_closed;
        @(posedge clk) disable iff (!rstn)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_write_closed: assert property (p_write_closed) else $error("write taken while busy");

    property p_write_answer;
        @(posedge clk) disable iff (!rstn)
        wr_go |=> s_axi_bvalid;
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("write not answered");

    property p_read_closed;
        @(posedge clk) disable iff (!rstn)
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_read_closed: assert property (p_read_closed) else $error("read taken while busy");

    property p_read_answer;
        @(posedge clk) disable iff (!rstn)
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid
            && s_axi_rdata == $past(next_rdata);
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
endmodule : canaf_filter

// ==== dv/canaf_engine_model.sv ====
`timescale 1ns/100ps
module canaf_engine_model (
    input wire logic clk,
    output canaf_pkg::canaf_rx_t rx
);
    initial rx = '0;

    // Outside the strobe the identifier lines carry the inverse of the last one.
    // A filter that samples them late then sees garbage instead of a stale match.
    task automatic send(input canaf_pkg::canaf_id_t id);
        @(posedge clk);
        rx <= '{valid: 1'b1, id: id};
        @(posedge clk);
        rx <= '{valid: 1'b0, id: ~id};
    endtask : send
endmodule : canaf_engine_model

// ==== dv/can_rx_acceptance_filter_test.sv ====
`timescale 1ns/100ps
module can_rx_acceptance_filter_test;
    logic clk, rstn;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    canaf_pkg::canaf_rx_t rx_in;
    canaf_pkg::canaf_verdict_t verdict;
    int bad_count, tests_run, n;
    logic [7:0] acc_cnt;
    logic [7:0] id_table [256];
    logic [31:0] rd_last;

    canaf_filter uut (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_in, .verdict);
    canaf_engine_model engine (.clk, .rx(rx_in));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic hang(input string nm);
        if (n >= 50) begin
            bad_count++;
            $display("mismatch %s expected answer seen none", nm);
            give_verdict();
        end
    endtask : hang

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
        logic aw, w;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw = 1'b1;
        w = 1'b1;
        n = 0;
        while ((aw || w) && n < 50) begin
            @(posedge clk);
            n++;
            if (aw && s_axi_awready === 1'b1) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready === 1'b1) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        do begin
            @(posedge clk);
            n++;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        s_axi_bready <= 1'b0;
        hang("bvalid");
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, resp});
    endtask : wr

    task automatic rdr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] resp,
                       input string nm);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (s_axi_arready !== 1'b1 && n < 50);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        s_axi_rready <= 1'b0;
        rd_last = s_axi_rdata;
        hang("rvalid");
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, resp});
        chk(nm, s_axi_rdata, exp);
    endtask : rdr

    function automatic canaf_pkg::canaf_id_t mk(input logic [1:0] ir, input logic [10:0] standard_id_bit,
                                                input logic [17:0] extended_id_bit);
        return {ir, standard_id_bit, extended_id_bit};
    endfunction : mk

    // Register word keeps a spare bit between the remote bit and the standard bits.
    function automatic logic [31:0] wd(input canaf_pkg::canaf_id_t id);
        return {id[30:29], 1'b0, id[28:0]};
    endfunction : wd

    task automatic msg(input canaf_pkg::canaf_id_t id, input logic acc, input logic fifo);
        engine.send(id);
        #1;
        chk("verdict", {29'h0, verdict}, {29'h0, 1'b1, acc, fifo});
        acc_cnt = acc_cnt + {7'h0, acc};
        rdr(canaf_pkg::ADDR_FILTER_SUPPORT, {16'h0, id.standard_id_bit[10:3], 8'h1 << id.standard_id_bit[2:0]},
            canaf_pkg::RESP_OKAY, "support");
    endtask : msg

    // Software side of the support unit: one byte per upper identifier byte.
    task automatic enlist(input logic [10:0] standard_id_bit);
        id_table[standard_id_bit[10:3]] = id_table[standard_id_bit[10:3]] | (8'h01 << standard_id_bit[2:0]);
    endtask : enlist

    task automatic look(input logic [10:0] standard_id_bit, input logic listed);
        engine.send(mk(2'h0, standard_id_bit, 18'h0));
        rdr(canaf_pkg::ADDR_FILTER_SUPPORT, {16'h0, standard_id_bit[10:3], 8'h01 << standard_id_bit[2:0]},
            canaf_pkg::RESP_OKAY, "support");
        chk("table", {31'h0, |(id_table[rd_last[15:8]] & rd_last[7:0])},
            {31'h0, listed});
    endtask : look

    initial begin
        rstn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        s_axi_awaddr = 8'h0;
        s_axi_araddr = 8'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        bad_count = 0;
        tests_run = 0;
        acc_cnt = 8'h0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        for (int a = 0; a <= 32; a += 4)
            rdr(8'(a), (8'(a) == canaf_pkg::ADDR_FILTER_SUPPORT) ? 32'h0000_0001
                : canaf_pkg::REG_RESET, canaf_pkg::RESP_OKAY, "reset value");
        rdr(8'h24, 32'h0, canaf_pkg::RESP_SLVERR, "unmapped");
        wr(canaf_pkg::ADDR_FILTER_SUPPORT, 32'hffff_ffff, canaf_pkg::RESP_SLVERR);
        wr(canaf_pkg::ADDR_CONTROL, 32'hffff_ffff, canaf_pkg::RESP_OKAY);
        rdr(canaf_pkg::ADDR_CONTROL, 32'h7, canaf_pkg::RESP_OKAY, "control");
        $display("test registers done");
        wr(canaf_pkg::ADDR_CONTROL, 32'h3, canaf_pkg::RESP_OKAY);
        wr(canaf_pkg::ADDR_MAILBOX_ID, wd(mk(2'h0, 11'h123, 18'h0)), 2'h0);
        wr(canaf_pkg::ADDR_MASK_ZERO, wd(mk(2'h3, 11'h7ff, 18'h0)), 2'h0);
        msg(mk(2'h0, 11'h123, 18'h3_ffff), 1'b1, 1'b0);
        msg(mk(2'h1, 11'h123, 18'h0), 1'b0, 1'b0);
        msg(mk(2'h0, 11'h122, 18'h0), 1'b0, 1'b0);
        msg(mk(2'h2, 11'h123, 18'h1_2345), 1'b1, 1'b0);
        wr(canaf_pkg::ADDR_CONTROL, {30'h0, canaf_pkg::ID_FORMAT_SELECT_MIXED}, 2'h0);
        msg(mk(2'h2, 11'h123, 18'h0), 1'b0, 1'b0);
        msg(mk(2'h0, 11'h123, 18'h0), 1'b1, 1'b0);
        wr(canaf_pkg::ADDR_MASK_ZERO, wd(mk(2'h3, 11'h7fe, 18'h0)), 2'h0);
        msg(mk(2'h0, 11'h122, 18'h0), 1'b1, 1'b0);
        msg(mk(2'h0, 11'h121, 18'h0), 1'b0, 1'b0);
        $display("test mailbox filter done");
        // Masks differ so that a swapped pairing accepts the wrong identifiers.
        wr(canaf_pkg::ADDR_CONTROL, 32'h4, canaf_pkg::RESP_OKAY);
        s_axi_wstrb <= 4'h1;
        wr(canaf_pkg::ADDR_MASK_SIX, 32'hffff_ffff, canaf_pkg::RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rdr(canaf_pkg::ADDR_MASK_SIX, 32'h0000_00ff, canaf_pkg::RESP_OKAY, "byte lane");
        wr(canaf_pkg::ADDR_MASK_SIX, wd(mk(2'h0, 11'h7ff, 18'h0)), 2'h0);
        wr(canaf_pkg::ADDR_MASK_SEVEN, wd(mk(2'h0, 11'h7f0, 18'h0)), 2'h0);
        wr(canaf_pkg::ADDR_FIFO_CMP_ZERO, wd(mk(2'h0, 11'h078, 18'h0)), 2'h0);
        wr(canaf_pkg::ADDR_FIFO_CMP_ONE, wd(mk(2'h0, 11'h110, 18'h0)), 2'h0);
        msg(mk(2'h0, 11'h078, 18'h0), 1'b1, 1'b1);
        msg(mk(2'h0, 11'h11f, 18'h0), 1'b1, 1'b1);
        msg(mk(2'h0, 11'h07f, 18'h0), 1'b0, 1'b1);
        msg(mk(2'h0, 11'h123, 18'h0), 1'b0, 1'b1);
        msg(mk(2'h3, 11'h6f4, 18'h2_aaaa), 1'b0, 1'b1);
        rdr(canaf_pkg::ADDR_STATUS, {24'h0, acc_cnt}, canaf_pkg::RESP_OKAY, "status");
        $display("test fifo filter done");
        for (int i = 0; i < 256; i++)
            id_table[i] = 8'h00;
        enlist(11'h000);
        enlist(11'h00d);
        enlist(11'h6f3);
        enlist(11'h6f4);
        enlist(11'h6ff);
        look(11'h6f4, 1'b1);
        look(11'h6f5, 1'b0);
        look(11'h00d, 1'b1);
        look(11'h00c, 1'b0);
        look(11'h6ff, 1'b1);
        $display("test support table done");
        give_verdict();
    end
endmodule : can_rx_acceptance_filter_test
